/* File: asc_ctrl.sv */
// Function
// RL1 - Sequence sixteen channels through sample-hold converter
// RL2 - Unread result overwritten raises overrun interrupt
// RL3 - Wait-for-read buffers result, holds conversion; done in continuous modes only, scan single overwrites the result
// RL4 - Unused analog inputs readable as digital
// RL5 - Single mode converts selected channel once
// RL6 - Continuous mode converts selected channel repeatedly
// RL7 - Scan single converts each channel once; the code converts only from the selected channel down to channel 0
// RL8 - Scan continuous cycles channels repeatedly
// RL9 - Scan results raise transfer request
// RL10 - Injected conversion stored separately, mode resumes
// RL11 - Conversion: 14 tcc, 2 tsc, 4 phases
// RL12 - Reset calibration 1.6ms with busy set
// RL13 - Conversions allowed, extending reset calibration
// RL14 - Four-clock calibration cycle after each conversion
// RL15 - Conversion clock 24, 96 or 48 phases
// RL16 - Sample clock one to eight conversion clocks
// RL17 - Software starts; busy clears when sequence ends
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
module asc_ctrl #(
  parameter int TCL_CYC = asc_pkg::TCL_CYC_DEF,
  parameter int CAL_TCL = asc_pkg::CAL_TCL_DEF
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [asc_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped
  output logic [asc_pkg::CH_W-1:0] afe_channel, // Mux channel
  output logic afe_sample, // Sample-and-hold active
  output logic afe_convert, // Conversion active
  output logic afe_calib, // Calibration active
  input wire logic [asc_pkg::RES_W-1:0] afe_code, // Converter code
  input wire logic [asc_pkg::NUM_CH-1:0] port_pins, // Analog pins as digital
  output logic xfer_req, // Result transfer request pulse
  output logic irq // Interrupt level
);
  import asc_pkg::*;
  localparam int DIV_W = $clog2(TCL_CYC + 1);
  localparam int CAL_W = $clog2(CAL_TCL + 1);
  // Elaboration check on the timing parameters
  if (TCL_CYC < 1 || CAL_TCL < 1) begin : g_param_chk
    $error("asc_ctrl: TCL_CYC and CAL_TCL must be at least 1");
  end
  // Phase length in base clock phases for a state
  function automatic logic [PH_W-1:0] phase_len(asc_state_t st, logic [1:0] ctc,
                                                logic [1:0] stc);
    logic [PH_W-1:0] tcc;
    logic [PH_W-1:0] tsc;
    tcc = TCC_24; // Reserved code runs as the fastest setting [RL15]
    if (ctc == CTC_96) begin
      tcc = TCC_96;
    end else if (ctc == CTC_48) begin
      tcc = TCC_48;
    end
    tsc = tcc << stc; // [RL16]
    case (st)
      S_SAMPLE: phase_len = PH_W'(tsc * SAMPLE_TSC); // [RL11]
      S_CONVERT: phase_len = PH_W'(tcc * CONV_TCC); // [RL11]
      S_XFER: phase_len = XFER_TCL; // [RL11]
      S_CALIB: phase_len = PH_W'(tcc * CAL_TCC); // [RL14]
      default: phase_len = XFER_TCL;
    endcase
  endfunction : phase_len
  asc_state_t state_r, state_nxt;
  logic [DIV_W-1:0] div_r;
  logic [PH_W-1:0] cnt_r;
  logic [CAL_W-1:0] cal_cnt_r;
  logic cal_active_r;
  logic [CH_W-1:0] ch_r, inj_ch_r, scan_ch_r;
  logic [1:0] mode_r, stc_r, ctc_r;
  logic start_r, wfr_r, inj_pend_r, cur_inj_r;
  logic [RES_W-1:0] code_r;
  logic [RES_W+CH_W-1:0] result_r, buf_r, inj_res_r;
  logic result_full_r, buf_full_r;
  logic [ST_W-1:0] st_r, mask_r, st_set;
  logic pready_r, pslverr_r, irq_r, xfer_req_r;
  logic [31:0] prdata_r, rd_data;
  logic acc, wr_ctrl, res_rd, tick, phase_end, rd_err, busy;
  logic cont, launch, inj_go, xfer_done, seq_end, store_main, hold_new;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign xfer_req = xfer_req_r;
  // base_clock_phase enable divider
  assign tick = (div_r == DIV_W'(TCL_CYC - 1));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (tick || (state_r == S_IDLE && state_nxt != S_IDLE)) begin // Align phases [RL11]
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
    end
  end
  // APB access decode
  assign acc = psel && penable && pready_r;
  assign wr_ctrl = acc && pwrite && (paddr == OFS_CTRL);
  assign res_rd = acc && !pwrite && (paddr == OFS_RESULT);
  assign cont = mode_r[0];
  assign busy = cal_active_r || (state_r != S_IDLE); // [RL12] [RL17]
  // Sequencer decisions
  assign phase_end = tick && (cnt_r == phase_len(state_r, ctc_r, stc_r) - PH_W'(1));
  assign xfer_done = (state_r == S_XFER) && phase_end;
  assign inj_go = inj_pend_r && cont && (state_r != S_IDLE); // [RL10]
  assign launch = (state_nxt == S_SAMPLE) && (state_r != S_SAMPLE);
  assign hold_new = cont && wfr_r && result_full_r && !res_rd; // [RL3]
  assign store_main = xfer_done && !cur_inj_r && !hold_new;
  assign seq_end = xfer_done && !cur_inj_r && !cont &&
                   ((mode_r == MODE_SINGLE) || (scan_ch_r == '0)); // [RL5] [RL7]
  // Next state of the conversion sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (start_r) begin
          state_nxt = S_SAMPLE; // [RL17]
        end
      end
      S_SAMPLE: begin
        if (phase_end) begin
          state_nxt = S_CONVERT; // [RL1]
        end
      end
      S_CONVERT: begin
        if (phase_end) begin
          state_nxt = S_XFER;
        end
      end
      S_XFER: begin
        if (phase_end) begin
          state_nxt = S_CALIB; // [RL14]
        end
      end
      S_CALIB: begin
        if (phase_end) begin
          if (buf_full_r) begin
            state_nxt = S_HOLD; // [RL3]
          end else if (start_r) begin
            state_nxt = S_SAMPLE; // [RL6] [RL8]
          end else begin
            state_nxt = S_IDLE;
          end
        end
      end
      S_HOLD: begin
        if (!buf_full_r) begin
          state_nxt = start_r ? S_SAMPLE : S_IDLE; // [RL3]
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end
  // State, phase counter and front-end strobes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      afe_sample <= 1'b0;
      afe_convert <= 1'b0;
      afe_calib <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        cnt_r <= '0;
      end else if (tick) begin
        cnt_r <= cnt_r + PH_W'(1);
      end
      afe_sample <= (state_nxt == S_SAMPLE); // [RL1]
      afe_convert <= (state_nxt == S_CONVERT);
      afe_calib <= (state_nxt == S_CALIB) || (cal_active_r && state_nxt == S_IDLE);
    end
  end
  // Channel selection and scan pointer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      afe_channel <= '0;
      scan_ch_r <= '0;
      cur_inj_r <= 1'b0;
    end else begin
      if (launch) begin
        cur_inj_r <= inj_go;
        if (inj_go) begin
          afe_channel <= inj_ch_r; // [RL10]
        end else if (state_r == S_IDLE) begin
          afe_channel <= ch_r;
          scan_ch_r <= ch_r;
        end else begin
          afe_channel <= scan_ch_r;
        end
      end
      if (xfer_done && !cur_inj_r) begin
        if (mode_r[1] && scan_ch_r != '0) begin
          scan_ch_r <= scan_ch_r - CH_W'(1); // [RL7] [RL8]
        end else begin
          scan_ch_r <= ch_r; // [RL6] [RL8]
        end
      end
    end
  end
  // Reset calibration, paused while a conversion runs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cal_cnt_r <= CAL_W'(CAL_TCL);
      cal_active_r <= 1'b1; // [RL12]
    end else if (cal_active_r && tick && state_r == S_IDLE) begin // [RL13]
      if (cal_cnt_r == CAL_W'(1)) begin
        cal_active_r <= 1'b0;
      end
      cal_cnt_r <= cal_cnt_r - CAL_W'(1);
    end
  end
  // Control register and start/injection requests
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ch_r <= '0;
      mode_r <= MODE_SINGLE;
      start_r <= 1'b0;
      wfr_r <= 1'b0;
      stc_r <= '0;
      ctc_r <= CTC_24;
      inj_ch_r <= '0;
      inj_pend_r <= 1'b0;
    end else begin
      if (seq_end) begin
        start_r <= 1'b0; // [RL17]
      end
      if (xfer_done && cur_inj_r) begin
        inj_pend_r <= 1'b0;
      end
      if (wr_ctrl) begin
        ch_r <= pwdata[CTRL_CH_LSB +: CH_W];
        mode_r <= pwdata[CTRL_MODE_LSB +: 2];
        start_r <= pwdata[CTRL_START_BIT];
        wfr_r <= pwdata[CTRL_WFR_BIT];
        stc_r <= pwdata[CTRL_STC_LSB +: 2];
        ctc_r <= pwdata[CTRL_CTC_LSB +: 2];
        inj_ch_r <= pwdata[CTRL_INJCH_LSB +: CH_W];
        if (pwdata[CTRL_INJ_BIT] && pwdata[CTRL_MODE_LSB]) begin
          inj_pend_r <= 1'b1; // [RL10]
        end
      end
    end
  end
  // Converter code captured at end of conversion
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      code_r <= '0;
    end else if (state_r == S_CONVERT && phase_end) begin
      code_r <= afe_code;
    end
  end
  // Result, wait-for-read buffer and injection result
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= '0;
      buf_r <= '0;
      inj_res_r <= '0;
      result_full_r <= 1'b0;
      buf_full_r <= 1'b0;
    end else begin
      if (res_rd) begin
        if (buf_full_r) begin
          result_r <= buf_r; // [RL3]
          buf_full_r <= 1'b0;
        end else begin
          result_full_r <= 1'b0;
        end
      end
      if (xfer_done && cur_inj_r) begin
        inj_res_r <= {afe_channel, code_r}; // [RL10]
      end else if (xfer_done && hold_new) begin
        buf_r <= {afe_channel, code_r}; // [RL3]
        buf_full_r <= 1'b1;
      end else if (store_main) begin
        result_r <= {afe_channel, code_r}; // [RL5] [RL6] [RL7] [RL8]
        result_full_r <= 1'b1;
      end
    end
  end
  // Status events
  always_comb begin
    st_set = '0;
    st_set[ST_DONE] = store_main;
    st_set[ST_OVR] = store_main && result_full_r && !res_rd; // [RL2]
    st_set[ST_INJ] = xfer_done && cur_inj_r;
    st_set[ST_CAL] = cal_active_r && tick && state_r == S_IDLE && cal_cnt_r == CAL_W'(1);
  end
  // Sticky status, write one to clear, set wins; mask and interrupt
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (acc && pwrite && paddr == OFS_STATUS) begin
        st_r <= (st_r & ~pwdata[ST_W-1:0]) | st_set;
      end else begin
        st_r <= st_r | st_set;
      end
      if (acc && pwrite && paddr == OFS_MASK) begin
        mask_r <= pwdata[ST_W-1:0];
      end
      irq_r <= |(st_r & mask_r); // [RL2]
    end
  end
  // Transfer request for scan results
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_req_r <= 1'b0;
    end else begin
      xfer_req_r <= store_main && mode_r[1]; // [RL9]
    end
  end
  // Read data decode
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (paddr == OFS_CTRL) begin
      rd_data[CTRL_CH_LSB +: CH_W] = ch_r;
      rd_data[CTRL_MODE_LSB +: 2] = mode_r;
      rd_data[CTRL_START_BIT] = start_r;
      rd_data[CTRL_BUSY_BIT] = busy; // [RL12]
      rd_data[CTRL_WFR_BIT] = wfr_r;
      rd_data[CTRL_INJ_BIT] = inj_pend_r;
      rd_data[CTRL_STC_LSB +: 2] = stc_r;
      rd_data[CTRL_CTC_LSB +: 2] = ctc_r;
      rd_data[CTRL_INJCH_LSB +: CH_W] = inj_ch_r;
    end else if (paddr == OFS_RESULT) begin
      rd_data[RES_W-1:0] = result_r[RES_W-1:0];
      rd_data[RES_CH_LSB +: CH_W] = result_r[RES_W +: CH_W];
    end else if (paddr == OFS_INJ) begin
      rd_data[RES_W-1:0] = inj_res_r[RES_W-1:0];
      rd_data[RES_CH_LSB +: CH_W] = inj_res_r[RES_W +: CH_W];
    end else if (paddr == OFS_STATUS) begin
      rd_data[ST_W-1:0] = st_r;
    end else if (paddr == OFS_MASK) begin
      rd_data[ST_W-1:0] = mask_r;
    end else if (paddr == OFS_DIGIN) begin
      rd_data[NUM_CH-1:0] = port_pins; // [RL4]
    end else begin
      rd_err = 1'b1;
    end
  end
  // APB slave: one wait state, then ready with data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (psel && penable && !pready_r) begin
      pready_r <= 1'b1;
      prdata_r <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr_r <= rd_err;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end
endmodule : asc_ctrl

/* File: asc_pkg.sv */
package asc_pkg;
  // APB map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_INJ = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_DIGIN = 8'h14;

  // converter_control_reg field positions
  localparam int CTRL_CH_LSB = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_START_BIT = 6;
  localparam int CTRL_BUSY_BIT = 7;
  localparam int CTRL_WFR_BIT = 8;
  localparam int CTRL_INJ_BIT = 9;
  localparam int CTRL_STC_LSB = 10;
  localparam int CTRL_CTC_LSB = 12;
  localparam int CTRL_INJCH_LSB = 14;

  // Result registers: value low, channel tag above
  localparam int RES_W = 10;
  localparam int CH_W = 4;
  localparam int NUM_CH = 16;
  localparam int RES_CH_LSB = 12;

  // Status / mask bits
  localparam int ST_W = 4;
  localparam int ST_DONE = 0;
  localparam int ST_OVR = 1;
  localparam int ST_INJ = 2;
  localparam int ST_CAL = 3;

  // Conversion modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_SCAN = 2'h2;
  localparam logic [1:0] MODE_SCAN_CONT = 2'h3;

  // Clock selections and phase multipliers (in base_clock_phase units)
  localparam logic [1:0] CTC_24 = 2'h0;
  localparam logic [1:0] CTC_RSVD = 2'h1;
  localparam logic [1:0] CTC_96 = 2'h2;
  localparam logic [1:0] CTC_48 = 2'h3;
  localparam int PH_W = 12;
  localparam logic [11:0] TCC_24 = 12'h018;
  localparam logic [11:0] TCC_96 = 12'h060;
  localparam logic [11:0] TCC_48 = 12'h030;
  localparam logic [11:0] CONV_TCC = 12'h00E;
  localparam logic [11:0] SAMPLE_TSC = 12'h002;
  localparam logic [11:0] XFER_TCL = 12'h004;
  localparam logic [11:0] CAL_TCC = 12'h004;

  // Timing: base_clock_phase and reset calibration
  localparam int CLK_NS = 5;
  localparam int TCL_NS = 20;
  localparam int TCL_CYC_DEF = (TCL_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAL_US = 1600;
  localparam int CAL_TCL_DEF = (CAL_US * 1000 + TCL_NS - 1) / TCL_NS;

  typedef enum logic [2:0] {
    S_IDLE,
    S_SAMPLE,
    S_CONVERT,
    S_XFER,
    S_CALIB,
    S_HOLD
  } asc_state_t;
endpackage : asc_pkg

/* File: asc_ctrl_sva.sv */
module asc_chk #(
  parameter int TCL_CYC = 1
) (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic afe_sample, // Sampling
  input wire logic afe_convert, // Converting
  input wire logic afe_calib, // Calibrating
  input wire logic xfer_req // Transfer request
);
  logic [12:0] smp_r;
  logic [12:0] cnv_r;
  localparam int CAL_DLY = 4 * TCL_CYC + 4; // Transfer phase plus margin
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Cycles spent in the running sample and convert phases
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      smp_r <= 13'h0000;
      cnv_r <= 13'h0000;
    end else begin
      smp_r <= afe_sample ? smp_r + 13'h0001 : 13'h0000;
      cnv_r <= afe_convert ? cnv_r + 13'h0001 : 13'h0000;
    end
  end
  AST_APB_READY: assert property (psel && $rose(penable) |=> pready)
    else $error("pready late");
  AST_APB_PULSE: assert property (pready |=> !pready) else $error("pready held");
  AST_APB_ERR: assert property (pslverr |-> pready) else $error("pslverr alone");
  AST_ONE_PHASE: assert property ($onehot0({afe_sample, afe_convert, afe_calib}))
    else $error("phases overlap");
  AST_SMP_TO_CNV: assert property ($fell(afe_sample) |-> afe_convert)
    else $error("no convert after sample");
  AST_CNV_LEN: assert property ($fell(afe_convert) |->
    int'(cnv_r) inside {336 * TCL_CYC, 672 * TCL_CYC, 1344 * TCL_CYC})
    else $error("convert length");
  AST_SMP_LEN: assert property ($fell(afe_sample) |->
    int'(smp_r) inside {48 * TCL_CYC, 96 * TCL_CYC, 192 * TCL_CYC, 384 * TCL_CYC,
    768 * TCL_CYC, 1536 * TCL_CYC}) else $error("sample length");
  AST_CAL_AFTER: assert property ($fell(afe_convert) |-> ##[1:CAL_DLY] afe_calib)
    else $error("no calibration after convert");
  AST_XFER_PULSE: assert property (xfer_req |=> !xfer_req) else $error("xfer_req held");
  AST_XFER_IDLE: assert property (xfer_req |-> !afe_sample && !afe_convert)
    else $error("xfer_req mid conversion");
  cover property ($fell(afe_convert));
  cover property (xfer_req);
  cover property (pslverr);
endmodule : asc_chk

bind asc_ctrl asc_chk #(.TCL_CYC(TCL_CYC)) u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .afe_sample(afe_sample),
  .afe_convert(afe_convert), .afe_calib(afe_calib), .xfer_req(xfer_req));

/* File: asc_afe_model.sv */
module asc_afe_model (
  input wire logic [asc_pkg::CH_W-1:0] afe_channel, // Channel under conversion
  input wire logic afe_convert, // Conversion phase
  output logic [asc_pkg::RES_W-1:0] afe_code // Code to the sequencer
);
  import asc_pkg::*;
  // Channel code while converting, inverted otherwise so stale reads show
  always_comb begin
    afe_code = {afe_channel, ~afe_channel, 2'b10};
    if (!afe_convert) begin
      afe_code = ~afe_code;
    end
  end
endmodule : asc_afe_model

/* File: asc_ctrl_tb_top.sv */
module asc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import asc_pkg::*;
  typedef struct packed {
    logic [3:0] ch;
    logic [1:0] stc;
    logic [1:0] ctc;
    logic [31:0] res;
  } asc_row_t;
  asc_row_t rows [4];
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [15:0] port_pins = 16'hA5C3;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] afe_channel;
  logic afe_sample;
  logic afe_convert;
  logic afe_calib;
  logic [9:0] afe_code;
  logic xfer_req;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  int n_fail = 0;
  int n_tests = 0;
  int nx = 0;
  int ncv = 0;
  int b;
  int c;
  asc_ctrl #(.TCL_CYC(1), .CAL_TCL(50)) dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .afe_channel(afe_channel), .afe_sample(afe_sample),
    .afe_convert(afe_convert), .afe_calib(afe_calib), .afe_code(afe_code),
    .port_pins(port_pins), .xfer_req(xfer_req), .irq(irq));
  asc_afe_model u_afe (.afe_channel(afe_channel), .afe_convert(afe_convert),
    .afe_code(afe_code));
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  // Count transfer requests and finished conversions
  always @(posedge xfer_req) nx++;
  always @(negedge afe_convert) ncv++;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      wrap_up();
    end
  endtask : apb
  task automatic wait_bit(input logic [7:0] a, input int bt, input logic v);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h00000000);
      k++;
    end while (rdat[bt] !== v && k < 2000);
    if (rdat[bt] !== v) begin
      n_fail++;
      wrap_up();
    end
  endtask : wait_bit
  task automatic wait_cv(input int n);
    int k;
    k = 0;
    while (ncv < n && k < 4000) begin
      @(posedge mclk);
      k++;
    end
    if (ncv < n) begin
      n_fail++;
      wrap_up();
    end
  endtask : wait_cv
  // Main sequence
  initial begin
    rows = '{'{4'h5, 2'h0, 2'h0, 32'h0000516A}, '{4'h9, 2'h1, 2'h3, 32'h0000925A},
      '{4'h2, 2'h0, 2'h2, 32'h000020B6}, '{4'hF, 2'h3, 2'h1, 32'h0000F3C2}};
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h00000000);
    chk("ctrl_rst", rdat, 32'h00000080);
    apb(1'b0, OFS_MASK, 32'h00000000);
    chk("mask_rst", rdat, 32'h00000000);
    wait_bit(OFS_STATUS, ST_CAL, 1'b1);
    apb(1'b0, OFS_CTRL, 32'h00000000);
    chk("busy_end", rdat, 32'h00000000);
    apb(1'b1, OFS_STATUS, 32'h0000000F);
    apb(1'b1, OFS_MASK, 32'h00000001);
    foreach (rows[i]) begin
      apb(1'b1, OFS_CTRL, {18'h0, rows[i].ctc, rows[i].stc, 6'h04, rows[i].ch});
      wait_bit(OFS_STATUS, ST_DONE, 1'b1);
      chk("irq_set", {31'h0, irq}, 32'h00000001);
      apb(1'b0, OFS_RESULT, 32'h00000000);
      chk("result", rdat, rows[i].res);
      wait_bit(OFS_CTRL, CTRL_BUSY_BIT, 1'b0);
      chk("ctrl_end", rdat & 32'h000000C0, 32'h00000000);
      apb(1'b1, OFS_STATUS, 32'h0000000F);
      repeat (2) @(posedge mclk);
      chk("irq_clr", {31'h0, irq}, 32'h00000000);
    end
    // Scan from channel two down, results left unread
    b = nx;
    apb(1'b1, OFS_CTRL, 32'h00000062);
    wait_bit(OFS_CTRL, CTRL_BUSY_BIT, 1'b0);
    chk("scan_reqs", nx - b, 32'h00000003);
    apb(1'b0, OFS_RESULT, 32'h00000000);
    chk("scan_last", rdat, 32'h0000003E);
    apb(1'b0, OFS_STATUS, 32'h00000000);
    chk("overrun", rdat & 32'h00000003, 32'h00000003);
    apb(1'b1, OFS_STATUS, 32'h0000000F);
    // Continuous mode holding on an unread result
    b = ncv;
    apb(1'b1, OFS_CTRL, 32'h00000153);
    wait_cv(b + 2);
    repeat (700) @(posedge mclk);
    chk("held", ncv - b, 32'h00000002);
    apb(1'b0, OFS_STATUS, 32'h00000000);
    chk("no_ovr", rdat & 32'h00000002, 32'h00000000);
    apb(1'b0, OFS_RESULT, 32'h00000000);
    chk("cont_1", rdat, 32'h000030F2);
    apb(1'b0, OFS_RESULT, 32'h00000000);
    chk("cont_2", rdat, 32'h000030F2);
    wait_cv(b + 3);
    // Channel seven injected into the running sequence
    apb(1'b1, OFS_CTRL, 32'h0001C253);
    wait_bit(OFS_STATUS, ST_INJ, 1'b1);
    apb(1'b0, OFS_INJ, 32'h00000000);
    chk("inj", rdat, 32'h000071E2);
    b = ncv;
    wait_cv(b + 2);
    apb(1'b0, OFS_RESULT, 32'h00000000);
    chk("inj_main", rdat, 32'h000030F2);
    // Unmapped offset and the digital pin view
    apb(1'b0, 8'h1C, 32'h00000000);
    chk("unmap_err", {31'h0, rerr}, 32'h00000001);
    chk("unmap_dat", rdat, 32'h00000000);
    apb(1'b0, OFS_DIGIN, 32'h00000000);
    chk("pins", rdat, 32'h0000A5C3);
    // Scan continuous from channel one, after stopping the running mode
    apb(1'b1, OFS_CTRL, 32'h00000000);
    wait_bit(OFS_CTRL, CTRL_BUSY_BIT, 1'b0);
    b = nx;
    c = ncv;
    apb(1'b1, OFS_CTRL, 32'h00000071);
    wait_cv(c + 3);
    repeat (10) @(posedge mclk);
    chk("scanc_reqs", nx - b, 32'h00000003);
    apb(1'b0, OFS_RESULT, 32'h00000000);
    chk("scanc_reload", rdat, 32'h0000107A);
    // Reset in mid-run, then a conversion inside the reset calibration
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h00000000);
    chk("ctrl_rst2", rdat, 32'h00000080);
    apb(1'b1, OFS_CTRL, 32'h00000045);
    wait_bit(OFS_STATUS, ST_DONE, 1'b1);
    chk("cal_ext", rdat & 32'h00000008, 32'h00000000);
    wait_bit(OFS_STATUS, ST_CAL, 1'b1);
    apb(1'b0, OFS_RESULT, 32'h00000000);
    chk("result_rst2", rdat, 32'h0000516A);
    wrap_up();
  end
endmodule : asc_ctrl_tb_top
